/* File: rtl/tqcs_lowpass.sv */
`timescale 1ns/1ps
module tqcs_lowpass
    import tqcs_pkg::*;
#(
    parameter int DT_NS = LOOP_PERIOD_NS,
    parameter int UNIT_NS = SMOOTH_UNIT_NS
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic loop_tick,
    input wire logic signed [15:0] x_in,
    input wire logic [15:0] tc,
    output logic signed [15:0] y_r
);
    if (DT_NS < 1 || UNIT_NS < 1)
    begin : g_bad_param
        $error("tqcs_lowpass: step and unit must be positive");
    end

    logic signed [31:0] acc_r;
    logic signed [31:0] acc_nxt;
    logic signed [31:0] x_acc;
    logic signed [63:0] diff;
    logic signed [63:0] step;
    logic [63:0] den;

    // First-order step: acc += (x - acc) * dt / tau, with 16 fraction bits.
    always_comb
    begin
        x_acc = {x_in, 16'h0000};
        diff = 64'(x_acc) - 64'(acc_r);
        den = 64'(tc) * 64'(UNIT_NS);
        step = (diff * 64'(DT_NS)) / $signed(den);
        if (den <= 64'(DT_NS))
            acc_nxt = x_acc;
        else
            acc_nxt = acc_r + 32'(step);
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            acc_r <= 32'sh00000000;
            y_r <= 16'sh0000;
        end
        else if (tc == 16'h0000)
        begin
            acc_r <= x_acc;
            y_r <= x_in;
        end
        else if (loop_tick)
        begin
            acc_r <= acc_nxt;
            y_r <= acc_nxt[31:16];
        end
    end

    chk_bypass_pass: assert property (@(posedge core_clk) disable iff (rst)
        tc == 16'h0000 |=> y_r == $past(x_in))
    else $error("Disabled filter did not pass its input through.");

    chk_hold_between: assert property (@(posedge core_clk) disable iff (rst)
        (tc != 16'h0000 && !loop_tick && $stable(tc)) |=> $stable(y_r))
    else $error("Filter output moved without a loop tick.");
endmodule : tqcs_lowpass

/* File: rtl/tqcs_pkg.sv */
package tqcs_pkg;
    localparam int ADDR_W = 12;
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [9:0] IDX_SMOOTH = 10'h10e;
    localparam logic [9:0] IDX_FSCALE = 10'h152;
    localparam logic [9:0] IDX_PRESET1 = 10'h200;
    localparam logic [9:0] IDX_PRESET2 = 10'h201;
    localparam logic [9:0] IDX_PRESET3 = 10'h202;
    localparam logic [9:0] IDX_MODE = 10'h203;
    localparam logic [9:0] IDX_RES_LPF = 10'h204;
    localparam logic [9:0] IDX_NOTCH_FREQ = 10'h205;
    localparam logic [9:0] IDX_NOTCH_DEPTH = 10'h206;
    localparam logic [9:0] IDX_STATUS = 10'h207;
    localparam logic [9:0] IDX_CMD = 10'h208;
    localparam logic [15:0] RST_SMOOTH = 16'h0000;
    localparam logic [15:0] RST_FSCALE = 16'h0064;
    localparam logic [15:0] RST_PRESET = 16'h0000;
    localparam logic [15:0] RST_RES_LPF = 16'h0000;
    localparam logic [15:0] RST_NOTCH_FREQ = 16'h03e8;
    localparam logic [15:0] RST_NOTCH_DEPTH = 16'h0000;
    localparam logic [15:0] SMOOTH_MAX = 16'h03e8;
    localparam logic [15:0] FSCALE_MAX = 16'h03e8;
    localparam logic [15:0] RES_LPF_MAX = 16'h03e8;
    localparam logic [15:0] NOTCH_FREQ_MIN = 16'h0032;
    localparam logic [15:0] NOTCH_FREQ_MAX = 16'h03e8;
    localparam logic [15:0] NOTCH_DEPTH_MAX = 16'h0020;
    localparam logic signed [15:0] PRESET_MAX = 16'sh012c;
    localparam logic signed [15:0] PRESET_MIN = 16'shfed4;
    // Analog input is in millivolts; 10 V is full scale.
    localparam logic signed [15:0] MV_FULL = 16'sh2710;
    localparam logic signed [31:0] SCALE_DIV = 32'sh000003e8;
    localparam logic signed [31:0] PCT_TO_TENTHS = 32'sh0000000a;
    // Commands are in tenths of a percent of rated torque.
    localparam logic signed [15:0] CMD_SAT = 16'sh2710;
    localparam int SMOOTH_UNIT_NS = 1000000;
    localparam int RES_LPF_UNIT_NS = 100000;
    localparam int LOOP_PERIOD_NS = 62500;

    typedef enum logic [1:0] {MODE_TORQUE_ANALOG, MODE_TORQUE_ZERO, MODE_POSITION, MODE_SPEED} tqcs_mode_t;
    typedef enum logic [3:0] {REG_NONE, REG_SMOOTH, REG_FSCALE, REG_PRESET1, REG_PRESET2, REG_PRESET3,
        REG_MODE, REG_RES_LPF, REG_NOTCH_FREQ, REG_NOTCH_DEPTH, REG_STATUS, REG_CMD} tqcs_reg_t;

    function automatic logic signed [15:0] sat16(input logic signed [31:0] v, input logic signed [15:0] lim);
        logic signed [31:0] l;
        l = 32'(lim);
        if (v > l)
            sat16 = lim;
        else if (v < -l)
            sat16 = -lim;
        else
            sat16 = v[15:0];
    endfunction : sat16
endpackage : tqcs_pkg

/* File: rtl/tqcs_scaler.sv */
`timescale 1ns/1ps
module tqcs_scaler
    import tqcs_pkg::*;
#(
    parameter logic signed [15:0] SAT_LIMIT = CMD_SAT
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic signed [15:0] mv_in,
    input wire logic [15:0] full_scale,
    output logic signed [15:0] pct_r
);
    logic signed [15:0] mv_c;
    logic signed [31:0] prod;
    logic signed [31:0] quo;

    always_comb
    begin
        if (mv_in > MV_FULL)
            mv_c = MV_FULL;
        else if (mv_in < -MV_FULL)
            mv_c = -MV_FULL;
        else
            mv_c = mv_in;
        prod = 32'(mv_c) * $signed({16'h0000, full_scale});
        quo = prod / SCALE_DIV;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            pct_r <= 16'sh0000;
        else
            pct_r <= sat16(quo, SAT_LIMIT);
    end

    chk_full_scale: assert property (@(posedge core_clk) disable iff (rst)
        (mv_in == MV_FULL && full_scale == RST_FSCALE) |=> pct_r == 16'sh03e8)
    else $error("Ten volts at setting 100 did not give 100 percent.");
endmodule : tqcs_scaler

/* File: rtl/tqcs_top.sv */
`timescale 1ns/1ps
// How it works
// - Sources are analog -10..+10 V and presets.
// - Selector input open is 0, closed 1.
// - Code 00: zero in zero mode, else analog.
// - Codes 01/10/11 pick presets one/two/three.
// - Preset choice changes only on selector change; preset value writes act at once.
// - Selector bits and control mode steer the mux.
// - Position and speed modes route value to limit.
// - Smoothing 0..1000 ms; zero means pass through.
// - Full scale 16-bit, 0..1000 percent, default 100.
// - Analog percent is volts times full scale over ten.
// - Full scale is reached at ten volts input.
// - Presets span -300 to +300 percent.
// - Larger resonance low-pass setting lowers its bandwidth.
// - Notch centre frequency accepts 50..1000 Hz.
// - Notch depth accepts 0..32 dB.
// - Current-loop gains are not user accessible.
// - Resonance low-pass zero disables; unit 0.1 ms.
// - Notch depth zero disables the whole notch group.
module tqcs_top
    import tqcs_pkg::*;
#(
    parameter int LOOP_NS = LOOP_PERIOD_NS,
    parameter logic signed [15:0] SAT_LIMIT = CMD_SAT
)
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic source_select_bit0,
    input wire logic source_select_bit1,
    input wire logic signed [15:0] analog_ref_mv,
    input wire logic loop_tick,
    output logic signed [15:0] torque_cmd,
    output logic signed [15:0] torque_limit,
    output logic limit_active,
    output logic [15:0] notch_freq_out,
    output logic [15:0] notch_depth_out,
    output logic notch_enable
);
    if (LOOP_NS < 1 || SAT_LIMIT < 16'sh0bb8)
    begin : g_bad_param
        $error("tqcs_top: loop period must be positive and the limit must cover the presets");
    end

    logic [15:0] torque_smoothing_constant_r;
    logic [15:0] analog_torque_full_scale_r;
    logic signed [15:0] preset_level_r [3];
    tqcs_mode_t control_mode_select_r;
    logic [15:0] resonance_lowpass_const_r;
    logic [15:0] notch_center_freq_r;
    logic [15:0] notch_depth_r;
    logic [1:0] sel_in;
    logic [1:0] sel_prev_r;
    logic [1:0] applied_code_r;
    tqcs_reg_t acc_reg;
    logic [15:0] cur_val;
    logic [15:0] wr_val;
    logic wr_ok;
    logic wr_en;
    logic torque_mode;
    logic signed [15:0] scaled_pct;
    logic signed [15:0] sel_value;
    logic signed [15:0] sel_value_r;
    logic signed [15:0] smooth_out;
    logic signed [15:0] res_out;

    function automatic tqcs_reg_t reg_decode(input logic [ADDR_W-1:0] a);
        tqcs_reg_t r;
        r = REG_NONE;
        if (a[1:0] == 2'b00)
        begin
            unique case (a[ADDR_W-1:2])
                IDX_SMOOTH: r = REG_SMOOTH;
                IDX_FSCALE: r = REG_FSCALE;
                IDX_PRESET1: r = REG_PRESET1;
                IDX_PRESET2: r = REG_PRESET2;
                IDX_PRESET3: r = REG_PRESET3;
                IDX_MODE: r = REG_MODE;
                IDX_RES_LPF: r = REG_RES_LPF;
                IDX_NOTCH_FREQ: r = REG_NOTCH_FREQ;
                IDX_NOTCH_DEPTH: r = REG_NOTCH_DEPTH;
                IDX_STATUS: r = REG_STATUS;
                IDX_CMD: r = REG_CMD;
                default: r = REG_NONE;
            endcase
        end
        return r;
    endfunction : reg_decode

    function automatic logic value_ok(input tqcs_reg_t r, input logic [15:0] v);
        logic ok;
        ok = 1'b0;
        unique case (r)
            REG_SMOOTH: ok = v <= SMOOTH_MAX;
            REG_FSCALE: ok = v <= FSCALE_MAX;
            REG_PRESET1, REG_PRESET2, REG_PRESET3: ok = $signed(v) >= PRESET_MIN && $signed(v) <= PRESET_MAX;
            REG_MODE: ok = v[15:2] == 14'h0000;
            REG_RES_LPF: ok = v <= RES_LPF_MAX;
            REG_NOTCH_FREQ: ok = v >= NOTCH_FREQ_MIN && v <= NOTCH_FREQ_MAX;
            REG_NOTCH_DEPTH: ok = v <= NOTCH_DEPTH_MAX;
            REG_STATUS, REG_CMD, REG_NONE: ok = 1'b0;
        endcase
        return ok;
    endfunction : value_ok

    // Current-loop gains have no address here; such accesses fall to the unmapped answer.
    assign acc_reg = reg_decode(paddr);
    assign wr_ok = value_ok(acc_reg, wr_val);
    assign wr_en = psel && penable && pwrite && pready && !pslverr;

    always_comb
    begin
        cur_val = 16'h0000;
        unique case (acc_reg)
            REG_SMOOTH: cur_val = torque_smoothing_constant_r;
            REG_FSCALE: cur_val = analog_torque_full_scale_r;
            REG_PRESET1: cur_val = preset_level_r[0];
            REG_PRESET2: cur_val = preset_level_r[1];
            REG_PRESET3: cur_val = preset_level_r[2];
            REG_MODE: cur_val = {14'h0000, control_mode_select_r};
            REG_RES_LPF: cur_val = resonance_lowpass_const_r;
            REG_NOTCH_FREQ: cur_val = notch_center_freq_r;
            REG_NOTCH_DEPTH: cur_val = notch_depth_r;
            REG_STATUS: cur_val = {10'h000, limit_active, notch_enable, control_mode_select_r, applied_code_r};
            REG_CMD: cur_val = torque_cmd;
            REG_NONE: cur_val = 16'h0000;
        endcase
        wr_val = {pstrb[1] ? pwdata[15:8] : cur_val[15:8], pstrb[0] ? pwdata[7:0] : cur_val[7:0]};
    end

    // The answer is prepared in the setup cycle so the access phase completes at once.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
        else
        begin
            pready <= psel && !penable;
            if (psel && !penable)
            begin
                prdata <= {16'h0000, cur_val};
                pslverr <= acc_reg == REG_NONE || (pwrite && !wr_ok);
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            torque_smoothing_constant_r <= RST_SMOOTH;
        else if (wr_en && acc_reg == REG_SMOOTH)
            torque_smoothing_constant_r <= wr_val;
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            analog_torque_full_scale_r <= RST_FSCALE;
        else if (wr_en && acc_reg == REG_FSCALE)
            analog_torque_full_scale_r <= wr_val;
    end

    for (genvar i = 0; i < 3; i++)
    begin : g_preset
        always_ff @(posedge core_clk or posedge rst)
        begin
            if (rst)
                preset_level_r[i] <= RST_PRESET;
            else if (wr_en && acc_reg == tqcs_reg_t'(4'(int'(REG_PRESET1) + i)))
                preset_level_r[i] <= wr_val;
        end

        chk_preset_range: assert property (@(posedge core_clk) disable iff (rst)
            preset_level_r[i] >= PRESET_MIN && preset_level_r[i] <= PRESET_MAX)
        else $error("Preset left its percent range.");
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            control_mode_select_r <= MODE_TORQUE_ANALOG;
        else if (wr_en && acc_reg == REG_MODE)
            control_mode_select_r <= tqcs_mode_t'(wr_val[1:0]);
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            resonance_lowpass_const_r <= RST_RES_LPF;
            notch_center_freq_r <= RST_NOTCH_FREQ;
            notch_depth_r <= RST_NOTCH_DEPTH;
        end
        else if (wr_en)
        begin
            if (acc_reg == REG_RES_LPF)
                resonance_lowpass_const_r <= wr_val;
            if (acc_reg == REG_NOTCH_FREQ)
                notch_center_freq_r <= wr_val;
            if (acc_reg == REG_NOTCH_DEPTH)
                notch_depth_r <= wr_val;
        end
    end

    assign sel_in = {source_select_bit1, source_select_bit0};

    // The applied code moves only when a selector bit changes.
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            sel_prev_r <= 2'b00;
            applied_code_r <= 2'b00;
        end
        else
        begin
            sel_prev_r <= sel_in;
            if (sel_in != sel_prev_r)
                applied_code_r <= sel_in;
        end
    end

    tqcs_scaler #(.SAT_LIMIT(SAT_LIMIT)) u_scale
    (
        .core_clk(core_clk),
        .rst(rst),
        .mv_in(analog_ref_mv),
        .full_scale(analog_torque_full_scale_r),
        .pct_r(scaled_pct)
    );

    always_comb
    begin
        sel_value = 16'sh0000;
        unique case (applied_code_r)
            2'b00: sel_value = control_mode_select_r == MODE_TORQUE_ZERO ? 16'sh0000 : scaled_pct;
            2'b01: sel_value = sat16(32'(preset_level_r[0]) * PCT_TO_TENTHS, SAT_LIMIT);
            2'b10: sel_value = sat16(32'(preset_level_r[1]) * PCT_TO_TENTHS, SAT_LIMIT);
            2'b11: sel_value = sat16(32'(preset_level_r[2]) * PCT_TO_TENTHS, SAT_LIMIT);
        endcase
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
            sel_value_r <= 16'sh0000;
        else
            sel_value_r <= sel_value;
    end

    tqcs_lowpass #(.DT_NS(LOOP_NS), .UNIT_NS(SMOOTH_UNIT_NS)) u_smooth
    (
        .core_clk(core_clk),
        .rst(rst),
        .loop_tick(loop_tick),
        .x_in(sel_value_r),
        .tc(torque_smoothing_constant_r),
        .y_r(smooth_out)
    );

    // A longer time constant narrows the resonance filter's bandwidth.
    tqcs_lowpass #(.DT_NS(LOOP_NS), .UNIT_NS(RES_LPF_UNIT_NS)) u_res_lpf
    (
        .core_clk(core_clk),
        .rst(rst),
        .loop_tick(loop_tick),
        .x_in(smooth_out),
        .tc(resonance_lowpass_const_r),
        .y_r(res_out)
    );

    assign torque_mode = control_mode_select_r == MODE_TORQUE_ANALOG || control_mode_select_r == MODE_TORQUE_ZERO;

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            torque_cmd <= 16'sh0000;
            torque_limit <= 16'sh0000;
            limit_active <= 1'b0;
        end
        else
        begin
            torque_cmd <= torque_mode ? res_out : 16'sh0000;
            torque_limit <= torque_mode ? 16'sh0000 : sel_value_r;
            limit_active <= !torque_mode;
        end
    end

    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            notch_freq_out <= 16'h0000;
            notch_depth_out <= 16'h0000;
            notch_enable <= 1'b0;
        end
        else
        begin
            notch_enable <= notch_depth_r != 16'h0000;
            notch_freq_out <= notch_depth_r == 16'h0000 ? 16'h0000 : notch_center_freq_r;
            notch_depth_out <= notch_depth_r;
        end
    end

    chk_zero_cmd: assert property (@(posedge core_clk) disable iff (rst)
        (applied_code_r == 2'b00 && control_mode_select_r == MODE_TORQUE_ZERO) |=> sel_value_r == 16'sh0000)
    else $error("Zero mode with code 00 gave a nonzero command.");

    chk_analog_src: assert property (@(posedge core_clk) disable iff (rst)
        (applied_code_r == 2'b00 && control_mode_select_r != MODE_TORQUE_ZERO) |=> sel_value_r == $past(scaled_pct))
    else $error("Code 00 did not select the scaled analog value.");

    chk_code_follow: assert property (@(posedge core_clk) disable iff (rst)
        sel_in != sel_prev_r |=> applied_code_r == $past(sel_in))
    else $error("Selector change was not applied.");

    chk_preset_hold: assert property (@(posedge core_clk) disable iff (rst)
        sel_in == sel_prev_r |=> $stable(applied_code_r))
    else $error("Applied code moved without a selector change.");

    chk_limit_route: assert property (@(posedge core_clk) disable iff (rst)
        !torque_mode |=> torque_cmd == 16'sh0000 && limit_active && torque_limit == $past(sel_value_r))
    else $error("Position or speed mode did not route to the limit.");

    chk_fscale_refuse: assert property (@(posedge core_clk) disable iff (rst)
        (psel && !penable && pwrite && acc_reg == REG_FSCALE && !wr_ok)
        |=> pslverr ##1 analog_torque_full_scale_r == $past(analog_torque_full_scale_r, 2))
    else $error("Out-of-range full scale write was not refused.");

    chk_notch_range: assert property (@(posedge core_clk) disable iff (rst)
        notch_center_freq_r >= NOTCH_FREQ_MIN && notch_center_freq_r <= NOTCH_FREQ_MAX)
    else $error("Notch frequency left its range.");

    chk_depth_off: assert property (@(posedge core_clk) disable iff (rst)
        notch_depth_r == 16'h0000 |=> !notch_enable && notch_freq_out == 16'h0000)
    else $error("Zero notch depth did not disable the group.");

    chk_sat_range: assert property (@(posedge core_clk) disable iff (rst)
        sel_value_r <= SAT_LIMIT && sel_value_r >= -SAT_LIMIT)
    else $error("Selected command exceeded the saturation limit.");

    cov_preset_three: cover property (@(posedge core_clk) disable iff (rst) applied_code_r == 2'b11);
    cov_zero_mode: cover property (@(posedge core_clk) disable iff (rst)
        applied_code_r == 2'b00 && control_mode_select_r == MODE_TORQUE_ZERO);
    cov_limit_mode: cover property (@(posedge core_clk) disable iff (rst) limit_active && torque_limit != 16'sh0000);
    cov_smoothing: cover property (@(posedge core_clk) disable iff (rst)
        loop_tick && torque_smoothing_constant_r != 16'h0000 && torque_mode);
endmodule : tqcs_top

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench
    import tqcs_pkg::*;
;
    typedef struct {logic [31:0] d; logic e; logic rd;} tqcs_note_t;
    logic core_clk, rst, psel, penable, pwrite, pready, pslverr, s0, s1, loop_tick, lact, ne;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic signed [15:0] mv, tcmd, tlim, want_mv;
    logic [15:0] nf, nd;
    logic [1:0] want_code;
    tqcs_note_t notes[$];
    tqcs_note_t mon_n;
    int failures, cmp_count, fs, v, p[4];

    tqcs_top u_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .source_select_bit0(s0), .source_select_bit1(s1), .analog_ref_mv(mv), .loop_tick(loop_tick),
        .torque_cmd(tcmd), .torque_limit(tlim), .limit_active(lact), .notch_freq_out(nf),
        .notch_depth_out(nd), .notch_enable(ne));
    tqcs_far_side u_far (.core_clk(core_clk), .want_code(want_code), .want_mv(want_mv),
        .source_select_bit0(s0), .source_select_bit1(s1), .analog_ref_mv(mv));

    initial
    begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp_val

    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd, input logic ee);
        int n;
        notes.push_back('{wd, ee, !wr});
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wr ? wd : 32'h0;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            failures++;
            wrap_up();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask : apb

    task automatic idle;
        repeat (12) @(posedge core_clk);
    endtask : idle

    // Each bus answer is matched against the oldest expectation noted by the driver.
    always @(posedge core_clk)
        if (psel && penable && pready === 1'b1)
        begin
            mon_n = notes.pop_front();
            cmp_val({31'h0, pslverr}, {31'h0, mon_n.e}, "pslverr");
            if (mon_n.rd)
                cmp_val(prdata, mon_n.d, "prdata");
        end

    always @(posedge core_clk)
        loop_tick <= ($urandom_range(15) == 0);

    initial
    begin
        void'($urandom(32'h7cb8));
        {rst, psel, penable, pwrite} = 4'h8;
        paddr = '0;
        pwdata = 32'h0;
        want_code = 2'b00;
        want_mv = 16'sh0000;
        repeat (5) @(posedge core_clk);
        rst <= 1'b0;
        apb(0, IDX_SMOOTH, 32'(RST_SMOOTH), 0);
        apb(0, IDX_FSCALE, 32'h64, 0);
        apb(0, IDX_NOTCH_FREQ, 32'h3e8, 0);
        apb(0, 10'h3ff, 32'h0, 1);
        $display("test reset_values done");
        apb(1, IDX_FSCALE, 32'h3e9, 1);
        apb(1, IDX_SMOOTH, 32'h3e9, 1);
        apb(1, IDX_RES_LPF, 32'h3e9, 1);
        apb(1, IDX_NOTCH_FREQ, 32'h31, 1);
        apb(1, IDX_NOTCH_FREQ, 32'h32, 0);
        apb(1, IDX_NOTCH_DEPTH, 32'h21, 1);
        apb(1, IDX_NOTCH_DEPTH, 32'h20, 0);
        apb(1, IDX_PRESET1, 32'h12d, 1);
        apb(1, IDX_STATUS, 32'h0, 1);
        idle();
        cmp_val({15'h0, ne, nf}, 32'h10032, "notch on");
        cmp_val({16'h0, nd}, 32'h20, "notch depth on");
        apb(1, IDX_NOTCH_DEPTH, 32'h0, 0);
        idle();
        cmp_val({15'h0, ne, nf}, 32'h0, "notch off");
        cmp_val({16'h0, nd}, 32'h0, "notch depth off");
        $display("test limits done");
        apb(1, IDX_MODE, 32'h0, 0);
        for (int i = 0; i < 5; i++)
        begin
            fs = (i == 0) ? 1000 : $urandom_range(1000);
            v = (i == 0) ? -10000 : $urandom_range(20000) - 10000;
            want_mv <= 16'(v);
            apb(1, IDX_FSCALE, 32'(fs), 0);
            idle();
            v = v * fs / 1000;
            apb(0, IDX_CMD, {16'h0, 16'(v)}, 0);
            cmp_val({16'h0, tcmd}, {16'h0, 16'(v)}, "torque_cmd");
        end
        $display("test analog done");
        // A step through both enabled filters must lag; disabling them must let it through at once.
        want_mv <= 16'sh0000;
        apb(1, IDX_FSCALE, 32'h64, 0);
        idle();
        apb(1, IDX_SMOOTH, 32'h1, 0);
        apb(1, IDX_RES_LPF, 32'h14, 0);
        apb(0, IDX_RES_LPF, 32'h14, 0);
        want_mv <= 16'sh2710;
        idle();
        cmp_val(32'(tcmd < 16'sh03e8), 32'h1, "smoothed step lags");
        apb(1, IDX_SMOOTH, 32'h0, 0);
        apb(1, IDX_RES_LPF, 32'h0, 0);
        idle();
        cmp_val({16'h0, tcmd}, 32'h3e8, "bypassed step");
        $display("test smoothing done");
        apb(1, IDX_MODE, 32'h1, 0);
        idle();
        apb(0, IDX_CMD, 32'h0, 0);
        for (int i = 1; i < 4; i++)
        begin
            p[i] = (i == 3) ? -300 : $urandom_range(600) - 300;
            apb(1, IDX_PRESET1 + 10'(i - 1), {16'h0, 16'(p[i])}, 0);
        end
        foreach (p[i])
            if (i > 0)
            begin
                want_code <= (i == 2) ? 2'd3 : ((i == 3) ? 2'd2 : 2'd1);
                idle();
                v = (i == 2) ? 3 : ((i == 3) ? 2 : 1);
                apb(0, IDX_CMD, {16'h0, 16'(p[v] * 10)}, 0);
                apb(0, IDX_STATUS, 32'(4 + v), 0);
            end
        $display("test presets done");
        want_code <= 2'd3;
        for (int m = 2; m < 4; m++)
        begin
            apb(1, IDX_MODE, 32'(m), 0);
            idle();
            apb(0, IDX_CMD, 32'h0, 0);
            cmp_val({15'h0, lact, tlim}, {16'h1, 16'(p[3] * 10)}, "limit");
            apb(0, IDX_STATUS, 32'(32 + m * 4 + 3), 0);
        end
        $display("test limit_modes done");
        wrap_up();
    end
endmodule : testbench

/* File: tb/tqcs_far_side.sv */
`timescale 1ns/1ps
module tqcs_far_side
    import tqcs_pkg::*;
(
    input wire logic core_clk,
    input wire logic [1:0] want_code,
    input wire logic signed [15:0] want_mv,
    output logic source_select_bit0,
    output logic source_select_bit1,
    output logic signed [15:0] analog_ref_mv
);
    initial
    begin
        source_select_bit0 = 1'b0;
        source_select_bit1 = 1'b0;
        analog_ref_mv = 16'sh0000;
    end
    // A closed contact reads 1; the voltage never leaves the +-10 V span.
    always @(posedge core_clk)
    begin
        source_select_bit0 <= want_code[0];
        source_select_bit1 <= want_code[1];
        analog_ref_mv <= (want_mv > MV_FULL) ? MV_FULL : ((want_mv < -MV_FULL) ? -MV_FULL : want_mv);
    end
endmodule : tqcs_far_side
